// *** inc/sdd_defs.svh ***
// timing counts and code constants for the step/dir drive front-end
`ifndef SDD_DEFS_SVH
`define SDD_DEFS_SVH
`define SDD_CLK_HZ        100000000
`define SDD_IDLE_S        1
`define SDD_IDLE_CYC      (`SDD_CLK_HZ * `SDD_IDLE_S)
`define SDD_PWM_HZ        16000
`define SDD_PWM_CYC       (`SDD_CLK_HZ / `SDD_PWM_HZ)
`define SDD_FILT_LO_HZ    150000
`define SDD_FILT_HI_HZ    500000
`define SDD_FILT_LO_CYC   (`SDD_CLK_HZ / (`SDD_FILT_LO_HZ * 2))
`define SDD_FILT_HI_CYC   (`SDD_CLK_HZ / (`SDD_FILT_HI_HZ * 2))
`define SDD_DEB_CYC       16'h2710
`define SDD_BASE_STEPS    32'h0000_00C8
`define SDD_TEST_REVS     2
`define SDD_TEST_RPS      1
`define SDD_IDLE_LO_PCT   7'h32
`define SDD_IDLE_HI_PCT   7'h5A
`define SDD_RUN_PCT       7'h64
`define SDD_SMOOTH_CYC    16'h0400
`define SDD_BLINK_CYC     32'd25000000
`define SDD_SETUP_CYC     32'd1000
`endif

// *** inc/sdd_pkg.sv ***
// types for the step/dir drive front-end
package sdd_pkg;
	typedef enum logic [2:0] {
		SDD_FLT_NONE, SDD_FLT_TEMP, SDD_FLT_INTV, SDD_FLT_OVV,
		SDD_FLT_UNV, SDD_FLT_OVC, SDD_FLT_OPEN
	} sdd_fault_t;
	typedef struct packed {
		logic over_temp;
		logic bad_int_v;
		logic over_v;
		logic under_v;
		logic over_i;
		logic open_wind;
	} sdd_faults_t;
	typedef struct packed {
		logic [31:0] steps_per_rev;
		logic [6:0]  current_pct;
		logic [4:0]  run_current_dA; // wide enough for 3.0 A in tenths
	} sdd_cfg_t;
endpackage : sdd_pkg

// *** rtl/sdd_top.sv ***
// command front-end, configuration decode and indicator logic of the stepper drive
`timescale 1ns/10ps
`include "sdd_defs.svh"

// Summary of operation
// [RL1] idle current holds 50% with idle switch on, else 90%
// [RL2] idle reduction only after one second without movement
// [RL3] family switch on: 200 times two to the three-bit index
// [RL4] family switch off: index picks 1000 through 20000 steps per rev
// [RL5] self-test switch on after power-up runs 2 revs each way at 1 rps
// [RL6] self-test checks internal and external supply, reports failure as fault
// [RL7] smoothing switch on filters step command with small delay
// [RL8] mode switch off step/dir, on separate cw and ccw pulses
// [RL9] inputs filtered to 150 kHz with noise switch on, else 500 kHz
// [RL10] each step activation advances exactly one microstep
// [RL11] steady indicator disabled, blinking enabled, red/green counts for faults
// [RL12] current control pwm timebase at fixed 16 kHz
// [RL13] automatic setup runs before normal operation
// [RL14] direction closed is clockwise, open is counterclockwise
// [RL15] enable closed turns off all bridge switches
// [RL16] falling enable clears latched faults and reactivates amplifier
// [RL17] three current switches decode 0.4 to 3.0 amps
// [RL18] every accepted step restarts the idle timer
// [RL19] configuration switches synchronised and debounced before use
module sdd_top import sdd_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        step_in,
	input  wire logic        dir_in,
	input  wire logic        enable_in,
	input  wire logic [2:0]  current_select,
	input  wire logic        idle_level_switch,
	input  wire logic        microstep_select_bit0,
	input  wire logic        microstep_select_bit1,
	input  wire logic        microstep_select_bit2,
	input  wire logic        microstep_family_switch,
	input  wire logic        selftest_switch,
	input  wire logic        smoothing_switch,
	input  wire logic        command_mode_switch,
	input  wire logic        noise_filter_switch,
	input  wire sdd_faults_t fault_in,
	input  wire logic        int_supply_ok,
	input  wire logic        ext_supply_ok,
	output logic             ustep_pulse,
	output logic             ustep_cw,
	output logic             bridge_enable,
	output sdd_cfg_t         cfg,
	output logic             pwm_sync,
	output logic             led_red,
	output logic             led_green,
	output logic             setup_done,
	output logic             selftest_active
);
	// switch bundle; ON reads as 1
	localparam int NSW = 12;
	logic [NSW-1:0] sw_raw, sw_s1, sw_s2, sw_db_r;
	logic [15:0]    deb_cnt_r [NSW];
	assign sw_raw = {current_select, idle_level_switch, microstep_select_bit0,
		microstep_select_bit1, microstep_select_bit2, microstep_family_switch,
		selftest_switch, smoothing_switch, command_mode_switch, noise_filter_switch};

	// two-flop sync then stable-count debounce per switch
	always_ff @(posedge sys_clk) begin
		sw_s1 <= rst ? '0 : sw_raw;
		sw_s2 <= rst ? '0 : sw_s1;
	end
	for (genvar i = 0; i < NSW; i++) begin : g_deb
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				deb_cnt_r[i] <= '0;
				sw_db_r[i]   <= 1'b0;
			end else if (sw_s2[i] == sw_db_r[i]) begin
				deb_cnt_r[i] <= '0;
			end else if (deb_cnt_r[i] == `SDD_DEB_CYC) begin
				sw_db_r[i]   <= sw_s2[i]; // RL19
				deb_cnt_r[i] <= '0;
			end else begin
				deb_cnt_r[i] <= deb_cnt_r[i] + 16'h0001;
			end
		end
	end
	// slices follow the bundle order above, noise switch in bit 0
	wire [2:0] cur_sel    = sw_db_r[11:9];
	wire       idle_lo    = sw_db_r[8];
	wire [2:0] ms_on      = sw_db_r[7:5];
	wire       ms_family  = sw_db_r[4];
	wire       st_sw      = sw_db_r[3];
	wire       smooth_sw  = sw_db_r[2];
	wire       mode_cwccw = sw_db_r[1];
	wire       nf_lo      = sw_db_r[0];

	// resolution decode: OFF counts as 1, first switch is lsb
	wire [2:0]  ms_idx = {~ms_on[0], ~ms_on[1], ~ms_on[2]};
	wire [31:0] res_pow2 = `SDD_BASE_STEPS << ms_idx; // RL3
	wire [31:0] res_dec =
		(ms_idx == 3'h0) ? 32'd1000 : (ms_idx == 3'h1) ? 32'd2000 :
		(ms_idx == 3'h2) ? 32'd4000 : (ms_idx == 3'h3) ? 32'd5000 :
		(ms_idx == 3'h4) ? 32'd6000 : (ms_idx == 3'h5) ? 32'd8000 :
		(ms_idx == 3'h6) ? 32'd10000 : 32'd20000; // RL4
	wire [31:0] res_nxt = ms_family ? res_pow2 : res_dec;
	// current decode in tenths of an amp; all ON is the lowest
	wire [2:0]  cur_idx = ~cur_sel; // first switch OFF adds the lowest step
	wire [3:0]  cur_nxt =
		(cur_idx == 3'h0) ? 4'h4 : (cur_idx == 3'h1) ? 4'h8 :
		(cur_idx == 3'h2) ? 4'hC : (cur_idx == 3'h3) ? 4'h0 :
		4'h0; // wide values carried by cur_full below
	logic [4:0] cur_full;
	assign cur_full = (cur_idx == 3'h3) ? 5'h10 : (cur_idx == 3'h4) ? 5'h14 :
		(cur_idx == 3'h5) ? 5'h18 : (cur_idx == 3'h6) ? 5'h1B :
		(cur_idx == 3'h7) ? 5'h1E : {1'b0, cur_nxt}; // RL17

	// input glitch filter: input must hold for the selected count
	wire [15:0] filt_len = nf_lo ? 16'(`SDD_FILT_LO_CYC) : 16'(`SDD_FILT_HI_CYC); // RL9
	logic [1:0]  in_r, filt_r;
	logic [15:0] fcnt_r [2];
	for (genvar k = 0; k < 2; k++) begin : g_flt
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				fcnt_r[k] <= '0;
				filt_r[k] <= 1'b0;
			end else if (in_r[k] == filt_r[k]) begin
				fcnt_r[k] <= '0;
			end else if (fcnt_r[k] >= filt_len - 16'h0001) begin
				filt_r[k] <= in_r[k];
				fcnt_r[k] <= '0;
			end else begin
				fcnt_r[k] <= fcnt_r[k] + 16'h0001;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		in_r <= rst ? 2'b00 : {dir_in, step_in};
	end

	// command decode; input high means closed
	logic [1:0] filt_d_r;
	always_ff @(posedge sys_clk) begin
		filt_d_r <= rst ? 2'b00 : filt_r;
	end
	wire rise0 = filt_r[0] & ~filt_d_r[0];
	wire rise1 = filt_r[1] & ~filt_d_r[1];
	wire cmd_step = mode_cwccw ? (rise0 | rise1) : rise0; // RL8 RL10
	wire cmd_cw   = mode_cwccw ? rise0 : filt_r[1]; // RL14

	// self-test and setup sequencing
	typedef enum logic [1:0] {SDD_SETUP, SDD_RUN, SDD_TEST_CW, SDD_TEST_CCW} sdd_seq_t;
	sdd_seq_t   seq_r;
	logic [31:0] seq_cnt_r, tst_steps_r;
	logic        st_armed_r, st_prev_r, test_pulse_r;
	wire [31:0] test_total = 32'(`SDD_TEST_REVS) * res_nxt;
	wire [31:0] test_per = 32'(`SDD_CLK_HZ) / (res_nxt * 32'(`SDD_TEST_RPS));
	wire st_rise = st_sw & ~st_prev_r;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seq_r <= SDD_SETUP;
			seq_cnt_r <= '0;
			tst_steps_r <= '0;
			st_armed_r <= 1'b0;
			st_prev_r <= 1'b0;
			test_pulse_r <= 1'b0;
		end else begin
			st_prev_r <= st_sw;
			test_pulse_r <= 1'b0;
			unique case (seq_r)
			SDD_SETUP: begin
				// motor parameter measurement window
				seq_cnt_r <= seq_cnt_r + 32'h1;
				if (seq_cnt_r == `SDD_SETUP_CYC) begin
					seq_r <= SDD_RUN; // RL13
					seq_cnt_r <= '0;
					st_armed_r <= 1'b1;
				end
			end
			SDD_RUN: begin
				if (st_armed_r && st_rise) begin
					seq_r <= SDD_TEST_CW; // RL5
					seq_cnt_r <= '0;
					tst_steps_r <= '0;
				end
			end
			SDD_TEST_CW, SDD_TEST_CCW: begin
				seq_cnt_r <= seq_cnt_r + 32'h1;
				if (!st_sw) begin
					seq_r <= SDD_RUN;
				end else if (seq_cnt_r >= test_per - 32'h1) begin
					seq_cnt_r <= '0;
					test_pulse_r <= 1'b1;
					tst_steps_r <= tst_steps_r + 32'h1;
					if (tst_steps_r == test_total - 32'h1) begin
						tst_steps_r <= '0;
						seq_r <= (seq_r == SDD_TEST_CW) ? SDD_TEST_CCW : SDD_RUN;
					end
				end
			end
			endcase
		end
	end
	wire in_test = (seq_r == SDD_TEST_CW) || (seq_r == SDD_TEST_CCW);

	// fault latch; supply check during self-test feeds voltage codes
	sdd_faults_t flt_r;
	logic        en_d_r;
	wire en_fall = en_d_r & ~enable_in;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flt_r <= '0;
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= enable_in;
			// new fault wins over the clearing edge
			flt_r <= (en_fall ? '0 : flt_r) | fault_in; // RL16
			if (in_test && !int_supply_ok) flt_r.bad_int_v <= 1'b1; // RL6
			if (in_test && !ext_supply_ok) flt_r.under_v <= 1'b1; // RL6
		end
	end
	wire any_fault = |flt_r;
	wire run_ok = !enable_in && !any_fault && (seq_r != SDD_SETUP);

	// smoothing: spread pulses by a minimum gap, queue depth counter
	logic [7:0]  pend_r;
	logic [15:0] gap_r;
	logic        pend_cw_r;
	wire src_step = in_test ? test_pulse_r : cmd_step;
	wire src_cw   = in_test ? (seq_r == SDD_TEST_CW) : cmd_cw;
	wire sm_fire = (pend_r != 8'h00) && (gap_r == 16'h0000);
	wire do_step = smooth_sw ? sm_fire : src_step; // RL7
	wire do_cw   = smooth_sw ? pend_cw_r : src_cw;
	always_ff @(posedge sys_clk) begin
		if (rst || !smooth_sw) begin
			pend_r <= '0;
			gap_r <= '0;
			pend_cw_r <= 1'b1;
		end else begin
			// limitation: a direction flip while queued takes the newest direction
			pend_r <= pend_r + {7'h0, src_step} - {7'h0, sm_fire};
			if (src_step) pend_cw_r <= src_cw;
			gap_r <= sm_fire ? `SDD_SMOOTH_CYC : (gap_r != 16'h0 ? gap_r - 16'h1 : gap_r);
		end
	end

	// idle timer, restarted by every accepted step
	logic [31:0] idle_cnt_r;
	wire idle_now = (idle_cnt_r == `SDD_IDLE_CYC);
	always_ff @(posedge sys_clk) begin
		if (rst || (do_step && run_ok)) idle_cnt_r <= '0; // RL18
		else if (!idle_now) idle_cnt_r <= idle_cnt_r + 32'h1; // RL2
	end

	// pwm timebase and blink timer
	logic [15:0] pwm_cnt_r;
	logic [31:0] blink_cnt_r;
	logic [3:0]  flash_r;
	logic        blink_r;
	wire pwm_wrap = (pwm_cnt_r == 16'(`SDD_PWM_CYC - 1));
	wire blink_tick = (blink_cnt_r == `SDD_BLINK_CYC - 32'h1);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pwm_cnt_r <= '0;
			blink_cnt_r <= '0;
			blink_r <= 1'b0;
			flash_r <= '0;
		end else begin
			pwm_cnt_r <= pwm_wrap ? 16'h0 : pwm_cnt_r + 16'h1; // RL12
			blink_cnt_r <= blink_tick ? 32'h0 : blink_cnt_r + 32'h1;
			if (blink_tick) begin
				blink_r <= ~blink_r;
				if (blink_r) flash_r <= (flash_r == 4'hA) ? 4'h0 : flash_r + 4'h1;
			end
		end
	end

	// fault code: red count, green count, then dark slots to fill eleven
	wire [3:0] n_red = flt_r.over_temp ? 4'h3 : flt_r.bad_int_v ? 4'h3 :
		flt_r.over_v ? 4'h4 : flt_r.under_v ? 4'h4 : flt_r.over_i ? 4'h5 : 4'h6;
	wire [3:0] n_grn = (flt_r.bad_int_v & ~flt_r.over_temp) |
		(flt_r.under_v & ~flt_r.over_v & ~flt_r.over_temp & ~flt_r.bad_int_v) ? 4'h2 : 4'h1;
	wire red_nxt = any_fault ? (!blink_r && flash_r < n_red) :
		1'b0;
	wire grn_nxt = any_fault ? (!blink_r && flash_r >= n_red && flash_r < n_red + n_grn) :
		(enable_in ? 1'b1 : blink_r); // RL11

	// registered outputs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ustep_pulse <= 1'b0;
			ustep_cw <= 1'b1;
			bridge_enable <= 1'b0;
			cfg <= '0;
			pwm_sync <= 1'b0;
			led_red <= 1'b0;
			led_green <= 1'b0;
			setup_done <= 1'b0;
			selftest_active <= 1'b0;
		end else begin
			ustep_pulse <= do_step && run_ok; // RL10
			if (do_step) ustep_cw <= do_cw; // RL14
			bridge_enable <= run_ok; // RL15
			cfg.steps_per_rev <= res_nxt;
			cfg.current_pct <= !idle_now ? `SDD_RUN_PCT :
				(idle_lo ? `SDD_IDLE_LO_PCT : `SDD_IDLE_HI_PCT); // RL1
			cfg.run_current_dA <= cur_full;
			pwm_sync <= pwm_wrap;
			led_red <= red_nxt;
			led_green <= grn_nxt;
			setup_done <= (seq_r != SDD_SETUP);
			selftest_active <= in_test;
		end
	end

	chk_idle_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL2
		(ustep_pulse |-> ##1 cfg.current_pct == `SDD_RUN_PCT)) else $error("idle too early");
	chk_enable_off: assert property (@(posedge sys_clk) disable iff (rst) // RL15
		(enable_in |=> !bridge_enable)) else $error("bridge on while disabled");
	chk_pwm_period: assert property (@(posedge sys_clk) disable iff (rst) // RL12
		(pwm_sync |-> ##1 !pwm_sync [*5])) else $error("pwm period short");
	chk_setup_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RL13
		(!setup_done |-> !ustep_pulse)) else $error("step during setup");
	chk_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RL15
		(enable_in |=> !ustep_pulse)) else $error("step while disabled");
	chk_fault_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL16
		((|fault_in) |=> (|flt_r))) else $error("fault not latched");
endmodule : sdd_top

// *** verification/sdd_indexer.sv ***
// behavioural step pulse indexer facing the drive command inputs
`timescale 1ns/10ps
module sdd_indexer (
	input  wire logic sys_clk,
	output logic      step_out,
	output logic      dir_out
);
	// both lines rest low so a later mode change sees no stray edge
	initial begin
		step_out = 1'b0;
		dir_out = 1'b0;
	end
	// hold is pulse width and spacing; a short hold plays a noise glitch
	task automatic send(input int n, input logic cw, input logic sep, input int hold);
		if (!sep) dir_out <= cw;
		for (int i = 0; i < n; i++) begin
			repeat (hold) @(posedge sys_clk);
			if (sep && !cw) dir_out <= 1'b1;
			else step_out <= 1'b1;
			repeat (hold) @(posedge sys_clk);
			if (sep && !cw) dir_out <= 1'b0;
			else step_out <= 1'b0;
		end
		repeat (hold) @(posedge sys_clk);
	endtask : send
endmodule : sdd_indexer

// *** verification/tb_sdd_top.sv ***
// self-checking bench for the drive front-end with an indexer model
`timescale 1ns/10ps
module tb_sdd_top import sdd_pkg::*;;
	logic        sys_clk, rst, enable_in, int_ok, ext_ok;
	logic [2:0]  cur_sel, ms_sel;
	logic        ms_fam, idle_sw, st_sw, sm_sw, mode_sw, nf_sw;
	sdd_faults_t fault_in;
	wire         step_w, dir_w;
	logic        ustep_pulse, ustep_cw, bridge_enable, pwm_sync;
	logic        led_red, led_green, setup_done, st_act, pend;
	sdd_cfg_t    cfg;
	int          n_fail = 0, checks_done = 0, cyc = 0, last_p = 0, hl[2] = '{60, 150};
	logic        exp_q[$];
	bit          ignore = 0, smooth = 0;
	sdd_top DUT (.sys_clk(sys_clk), .rst(rst), .step_in(step_w), .dir_in(dir_w),
		.enable_in(enable_in), .current_select(cur_sel), .idle_level_switch(idle_sw),
		.microstep_select_bit0(ms_sel[0]), .microstep_select_bit1(ms_sel[1]),
		.microstep_select_bit2(ms_sel[2]), .microstep_family_switch(ms_fam),
		.selftest_switch(st_sw), .smoothing_switch(sm_sw), .command_mode_switch(mode_sw),
		.noise_filter_switch(nf_sw), .fault_in(fault_in), .int_supply_ok(int_ok),
		.ext_supply_ok(ext_ok), .ustep_pulse(ustep_pulse), .ustep_cw(ustep_cw),
		.bridge_enable(bridge_enable), .cfg(cfg), .pwm_sync(pwm_sync), .led_red(led_red),
		.led_green(led_green), .setup_done(setup_done), .selftest_active(st_act));
	sdd_indexer u_idx (.sys_clk(sys_clk), .step_out(step_w), .dir_out(dir_w));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_v
	task automatic chk_b(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_b
	task automatic results;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic done(input string nm);
		$display("test %s finished, mismatches so far %0d", nm, n_fail);
	endtask : done
	// reference decode: an OFF switch counts as one, first switch lowest
	function automatic logic [31:0] m_spr(input logic f, input logic [2:0] s);
		int t[8] = '{1000, 2000, 4000, 5000, 6000, 8000, 10000, 20000};
		return f ? 32'(200 << 3'(~s)) : 32'(t[3'(~s)]);
	endfunction : m_spr
	function automatic logic [4:0] m_cur(input logic [2:0] s);
		int t[8] = '{4, 8, 12, 16, 20, 24, 27, 30};
		return 5'(t[3'(~s)]);
	endfunction : m_cur
	function automatic logic sig(input int s);
		case (s)
			0: return setup_done;
			1: return bridge_enable;
			2: return st_act;
			3: return exp_q.size() == 0;
			default: return pwm_sync;
		endcase
	endfunction : sig
	// bounded wait on negedge so registered outputs have settled
	task automatic wt(input int s, input logic v, input int lim);
		for (int i = 0; i < lim && sig(s) !== v; i++) @(negedge sys_clk);
		if (sig(s) !== v) begin
			n_fail++;
			$display("wrong value wait %0d expected %b seen %b", s, v, sig(s));
			results();
		end
	endtask : wt
	task automatic cfg_chk;
		chk_v("steps_per_rev", m_spr(ms_fam, ms_sel), cfg.steps_per_rev);
		chk_v("run_current", m_cur(cur_sel), cfg.run_current_dA);
		chk_v("current_pct", 32'h0000_0064, cfg.current_pct);
	endtask : cfg_chk
	// queue one expected direction per accepted step, then drain
	task automatic steps(input int n, input logic cw, input logic sep, input int h, input bit ac);
		@(posedge sys_clk);
		if (ac) repeat (n) exp_q.push_back(cw);
		u_idx.send(n, cw, sep, h);
		wt(3, 1'b1, 6000);
		repeat (400) @(negedge sys_clk);
	endtask : steps
	// every pulse while ignore is clear is matched against the model queue a cycle later
	always @(negedge sys_clk) begin
		cyc <= cyc + 1;
		if (pend && exp_q.size() == 0) chk_b("extra ustep_pulse", 1'b0, 1'b1);
		else if (pend) chk_b("ustep_cw", exp_q.pop_front(), ustep_cw);
		pend <= (ustep_pulse === 1'b1) && !ignore;
		if (ustep_pulse === 1'b1) begin
			if (smooth) chk_b("smooth gap", 1'b1, (cyc - last_p) >= 1025);
			last_p <= cyc;
		end
	end
	initial begin
		int n;
		{rst, enable_in, int_ok, ext_ok, fault_in} = {4'b1011, 6'h00};
		{st_sw, sm_sw, mode_sw, nf_sw, idle_sw, ms_fam} = 6'h03;
		void'($urandom(32'h2197));
		ms_sel = 3'($urandom);
		cur_sel = 3'($urandom);
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		wt(0, 1'b1, 12000);
		repeat (10100) @(negedge sys_clk);
		cfg_chk();
		chk_b("bridge_enable", 1'b1, bridge_enable);
		chk_b("selftest_active", 1'b0, st_act);
		done("config");
		steps($urandom_range(5, 2), 1'b1, 1'b0, 150, 1);
		steps(3, 1'b0, 1'b0, 150, 1);
		for (int i = 0; i < 2; i++) steps(1, 1'b0, 1'b0, hl[i], hl[i] > 100);
		done("step dir");
		@(posedge sys_clk) enable_in <= 1'b1;
		wt(1, 1'b0, 500);
		chk_b("led_green", 1'b1, led_green);
		chk_b("led_red", 1'b0, led_red);
		steps(2, 1'b0, 1'b0, 150, 0);
		@(posedge sys_clk) enable_in <= 1'b0;
		wt(1, 1'b1, 500);
		@(posedge sys_clk) fault_in.over_temp <= 1'b1;
		wt(1, 1'b0, 500);
		@(posedge sys_clk) fault_in <= '0;
		repeat (500) @(negedge sys_clk);
		chk_b("fault latched", 1'b0, bridge_enable);
		@(posedge sys_clk) enable_in <= 1'b1;
		repeat (400) @(posedge sys_clk);
		enable_in <= 1'b0;
		wt(1, 1'b1, 500);
		done("enable fault");
		wt(4, 1'b1, 7000);
		@(negedge sys_clk);
		for (n = 1; n < 7000 && pwm_sync !== 1'b1; n++) @(negedge sys_clk);
		chk_v("pwm period", 32'h0000_186A, n);
		done("pwm");
		@(posedge sys_clk);
		{ms_fam, mode_sw, nf_sw, sm_sw} <= 4'h7;
		ms_sel <= 3'($urandom);
		repeat (10100) @(negedge sys_clk);
		cfg_chk();
		smooth = 1;
		steps(1, 1'b1, 1'b1, 200, 0);
		steps(3, 1'b1, 1'b1, 400, 1);
		steps(2, 1'b0, 1'b1, 400, 1);
		smooth = 0;
		done("cw ccw smoothing");
		// test moves run far longer than the bench, so their pulses are not matched
		@(posedge sys_clk);
		ignore = 1;
		{int_ok, st_sw} <= 2'b01;
		wt(2, 1'b1, 10300);
		wt(1, 1'b0, 2000);
		done("selftest");
		results();
	end
endmodule : tb_sdd_top
